// File: hw/serial_rx_pkg.sv
/*
  Constants and carrier types for the receiver status and wakeup block.
  Assumes a single 100 MHz clock domain and a 16x sample tick from a divider.
*/
package serial_rx_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam logic [15:0] TICK_DIV_RESET = 16'h0036;
  localparam int          TICKS_PER_BIT  = 16;
  localparam logic [3:0]  START_S1       = 4'h3;
  localparam logic [3:0]  START_S2       = 4'h5;
  localparam logic [3:0]  START_S3       = 4'h7;
  localparam logic [3:0]  SAMP_A         = 4'h8;
  localparam logic [3:0]  SAMP_B         = 4'h9;
  localparam logic [3:0]  SAMP_C         = 4'ha;
  localparam logic [3:0]  LAST_TICK      = 4'hf;
  localparam int          STOP_TICKS_8   = 154;
  localparam int          STOP_TICKS_9   = 170;
  localparam logic [3:0]  IDLE_BITS_8    = 4'ha;
  localparam logic [3:0]  IDLE_BITS_9    = 4'hb;

  localparam logic [3:0] REG_CTRL_ONE  = 4'h0;
  localparam logic [3:0] REG_CTRL_TWO  = 4'h1;
  localparam logic [3:0] REG_CTRL_THR  = 4'h2;
  localparam logic [3:0] REG_STATUS    = 4'h3;
  localparam logic [3:0] REG_DATA      = 4'h4;
  localparam logic [3:0] REG_BREAK     = 4'h5;
  localparam logic [3:0] REG_DIV       = 4'h6;

  // Control one: bit0 nine-bit mode, bit1 wake method, bit2 idle type,
  // bit3 parity enable, bit4 odd parity, bit5 receiver enable.
  localparam int C1_NINE = 0;
  localparam int C1_WAKE = 1;
  localparam int C1_IDLE_COUNT_TYPE_BIT = 2;
  localparam int C1_PEN  = 3;
  localparam int C1_PODD = 4;
  localparam int C1_REN  = 5;
  // Control two: bit0 full irq en, bit1 idle irq en, bit2 standby bit.
  localparam int C2_RFIE = 0;
  localparam int C2_IDLE_IRQ_ENABLE = 1;
  localparam int C2_STBY = 2;
  // Control three: bit0 overrun, bit1 noise, bit2 framing, bit3 parity enables.
  // Status: bit0 full, bit1 idle, bit2 overrun, bit3 noise, bit4 framing, bit5 parity.
  localparam int S_FULL = 0;
  localparam int S_IDLE = 1;
  localparam int S_OVR  = 2;
  localparam int S_NF   = 3;
  localparam int S_FE   = 4;
  localparam int S_PE   = 5;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} rx_state_t;
endpackage

// File: hw/serial_rx_status.sv
/*
  Receiver framing, noise, wakeup and status flags with two interrupt requests.
  Assumes synchronous rxd, synchronous register port with read data one cycle later,
  and a gated clock that simply stops during stop mode.
*/
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Stop sample not 1 sets the framing error flag.
// R2 - A break character without stop bit also sets framing error.
// R3 - Framing error rises in the same cycle as receive full.
// R4 - Three stop samples: one miss gives noise, more give framing error.
// R5 - Sample counter resyncs on each valid falling edge inside a character.
// R6 - Sixteen ticks per bit; stop sampled at ticks 8,9,10; ends 154 or 170.
// R7 - Standby bit suppresses all receiver interrupt requests.
// R8 - Address-mark wakeup: MSB one clears standby and sets receive full.
// R9 - Idle wakeup clears standby without setting idle or receive full.
// R10 - Idle type selects idle count start after start bit or stop bit.
// R11 - Setting standby on an already idle line wakes again.
// R12 - Receive full set on buffer load; requests interrupt when enabled.
// R13 - Idle flag after 10 or 11 ones; requests interrupt when enabled.
// R14 - Overrun keeps old character, drops new one, gated error request.
// R15 - Noise in start, data or stop bits sets noise flag.
// R16 - Parity mismatch sets parity flag; parity and framing gate error request.
// R17 - Wait mode keeps receiver running; enabled requests wake processor.
// R18 - Stop mode halts clock, keeps registers, resumes after exit.
// R19 - Break clear enable 1 lets software clears act during debug break.
// R20 - Break clear enable 0 freezes flags; two-step clear finishes afterwards.
// R21 - Idle type 1 counts after stop bit, 0 after start; reset clears.
// R22 - Wake method 1 is address mark, 0 idle line; reset clears.
// R23 - Four gated error flags form one error request, separate from receiver.
module serial_rx_status
  import serial_rx_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Serial line and debug state
  input  wire logic       rxd,
  input  wire logic       debug_break,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Interrupt requests
  output logic            rx_irq,
  output logic            err_irq
);

  reg_req_t   req;
  logic [5:0] ctrl_one;
  logic [2:0] ctrl_two;
  logic [3:0] ctrl_three;
  logic [5:0] status;
  logic       break_clr_en;
  logic [15:0] tick_div;
  logic [15:0] div_cnt;
  logic       tick;
  rx_state_t  state;
  logic [3:0] rt;
  logic [3:0] bit_idx;
  logic [2:0] samp;
  logic [8:0] shreg;
  logic       prev_bit;
  logic       prev_line;
  logic       noise_acc;
  logic [7:0] data_buf;
  logic [3:0] ones_cnt;
  logic       idle_armed;
  logic       armed_first;
  logic       first_step;
  logic [7:0] ticks_since_start;

  logic       can_clear;
  logic       char_done;
  logic       stop_ok;
  logic       stop_noise;
  logic       parity_bad;
  logic       wake_mark;
  logic       idle_hit;
  logic [3:0] last_bit;
  logic [3:0] idle_need;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic mixed(input logic [2:0] s);
    mixed = (s != 3'b000) && (s != 3'b111);
  endfunction

  // Register writes; flags frozen under break unless clear enable is set.
  assign can_clear = !debug_break || break_clr_en; // R19 R20

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_one     <= '0; // R21 R22
      ctrl_three   <= '0;
      break_clr_en <= 1'b0;
      tick_div     <= TICK_DIV_RESET;
    end else if (req.wr) begin
      unique case (req.addr)
        REG_CTRL_ONE: ctrl_one <= req.wdata[5:0];
        REG_CTRL_THR: ctrl_three <= req.wdata[3:0];
        REG_BREAK:    break_clr_en <= req.wdata[0];
        REG_DIV:      tick_div <= {8'h00, req.wdata};
        default: ;
      endcase
    end
  end

  // Sample tick divider; the clock stops in stop mode so state is simply held.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (div_cnt >= tick_div) begin // R18
      div_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  assign last_bit  = ctrl_one[C1_NINE] ? 4'ha : 4'h9;
  assign idle_need = ctrl_one[C1_NINE] ? IDLE_BITS_9 : IDLE_BITS_8;
  // The third stop sample is the live line, since the flags load on that same tick.
  assign stop_ok    = majority({rxd, samp[1:0]});
  assign stop_noise = mixed({rxd, samp[1:0]}); // R4
  assign char_done  = tick && ctrl_one[C1_REN] && state == RX_BITS &&
                      bit_idx == last_bit && rt == SAMP_C;
  assign parity_bad = ctrl_one[C1_PEN] &&
                      ((ctrl_one[C1_NINE] ? ^shreg[8:0] : ^shreg[8:1]) != ctrl_one[C1_PODD]);
  assign wake_mark  = shreg[8];

  // Receiver sampling; runs identically in wait mode.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= RX_HUNT;
      rt        <= '0;
      bit_idx   <= '0;
      samp      <= '0;
      shreg     <= '0;
      prev_bit  <= 1'b1;
      prev_line <= 1'b1;
      noise_acc <= 1'b0;
      ticks_since_start <= '0;
    end else if (tick && ctrl_one[C1_REN]) begin // R17
      prev_line <= rxd;
      unique case (state)
        RX_HUNT: begin
          // The counter runs free while hunting so idle ones are counted per bit time.
          rt <= rt + 4'h1;
          if (prev_line && !rxd) begin
            state <= RX_START;
            rt <= 4'h2;
            samp <= '0;
            noise_acc <= 1'b0;
            ticks_since_start <= 8'h02;
          end
        end
        RX_START: begin
          rt <= rt + 4'h1;
          ticks_since_start <= ticks_since_start + 8'h01;
          if (rt == START_S1) samp[0] <= rxd;
          if (rt == START_S2) samp[1] <= rxd;
          if (rt == START_S3) begin
            if (majority({rxd, samp[1:0]})) state <= RX_HUNT;
            else if (mixed({rxd, samp[1:0]})) noise_acc <= 1'b1; // R15
          end
          if (rt == LAST_TICK) begin
            state <= RX_BITS;
            bit_idx <= 4'h1;
            prev_bit <= 1'b0;
          end
        end
        RX_BITS: begin
          rt <= rt + 4'h1; // R6
          ticks_since_start <= ticks_since_start + 8'h01;
          if (rt == SAMP_A) samp[0] <= rxd;
          if (rt == SAMP_B) samp[1] <= rxd;
          if (rt == SAMP_C) begin
            if (mixed({rxd, samp[1:0]}) && bit_idx != last_bit) noise_acc <= 1'b1; // R15
            if (bit_idx == last_bit) begin
              samp[2] <= rxd;
              state <= RX_HUNT;
            end else begin
              shreg <= {majority({rxd, samp[1:0]}), shreg[8:1]};
              prev_bit <= majority({rxd, samp[1:0]});
              bit_idx <= bit_idx + 4'h1;
            end
          end
          if (rt > SAMP_C && prev_bit && prev_line && !rxd) rt <= 4'h2; // R5
        end
        default: state <= RX_HUNT;
      endcase
    end
  end

  // Idle counter of consecutive ones; start point set by the idle type bit.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_cnt   <= '0;
      idle_armed <= 1'b0;
    end else if (tick && ctrl_one[C1_REN]) begin
      if (!rxd) begin
        ones_cnt   <= '0;
        idle_armed <= 1'b0;
      end else if (rt == SAMP_B && ones_cnt != idle_need) begin
        if (state == RX_HUNT || !ctrl_one[C1_IDLE_COUNT_TYPE_BIT]) begin // R10 R21
          ones_cnt <= ones_cnt + 4'h1;
          idle_armed <= 1'b1;
        end
      end
    end
  end

  assign idle_hit = ones_cnt == idle_need && idle_armed; // R13

  // Status flags; hardware set wins over software clear.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status      <= '0;
      data_buf    <= '0;
      ctrl_two    <= '0;
      first_step  <= 1'b0;
      armed_first <= 1'b0;
    end else begin
      if (req.wr && req.addr == REG_CTRL_TWO) ctrl_two <= req.wdata[2:0];
      if (req.rd && req.addr == REG_STATUS && can_clear) first_step <= 1'b1; // R20
      if (req.rd && req.addr == REG_DATA && first_step && can_clear) begin
        status[S_FULL] <= 1'b0; // R19
        status[S_OVR]  <= 1'b0;
        status[S_NF]   <= 1'b0;
        status[S_FE]   <= 1'b0;
        status[S_PE]   <= 1'b0;
        status[S_IDLE] <= 1'b0;
        first_step     <= 1'b0;
      end
      if (idle_hit) begin
        if (ctrl_two[C2_STBY] && !ctrl_one[C1_WAKE]) ctrl_two[C2_STBY] <= 1'b0; // R9 R11
        else if (!ctrl_two[C2_STBY] && !armed_first) status[S_IDLE] <= 1'b1;
      end
      armed_first <= idle_hit;
      if (char_done && !(ctrl_two[C2_STBY] && !(ctrl_one[C1_WAKE] && wake_mark))) begin
        if (ctrl_two[C2_STBY]) ctrl_two[C2_STBY] <= 1'b0; // R8 R22
        if (status[S_FULL]) status[S_OVR] <= 1'b1; // R14
        else begin
          data_buf <= ctrl_one[C1_NINE] ? shreg[7:0] : shreg[8:1];
          status[S_FULL] <= 1'b1; // R12
          status[S_FE] <= !stop_ok; // R1 R2 R3
          status[S_NF] <= stop_noise || noise_acc; // R4 R15
          status[S_PE] <= parity_bad; // R16
        end
      end
    end
  end

  // Read data and interrupt requests, all registered.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
      rx_irq    <= 1'b0;
      err_irq   <= 1'b0;
    end else begin
      reg_rdata <= '0;
      if (req.rd) begin
        unique case (req.addr)
          REG_CTRL_ONE: reg_rdata <= {2'b00, ctrl_one};
          REG_CTRL_TWO: reg_rdata <= {5'b00000, ctrl_two};
          REG_CTRL_THR: reg_rdata <= {4'h0, ctrl_three};
          REG_STATUS:   reg_rdata <= {2'b00, status};
          REG_DATA:     reg_rdata <= data_buf;
          REG_BREAK:    reg_rdata <= {7'h00, break_clr_en};
          REG_DIV:      reg_rdata <= tick_div[7:0];
          default:      reg_rdata <= '0;
        endcase
      end
      rx_irq <= !ctrl_two[C2_STBY] && // R7
                ((status[S_FULL] && ctrl_two[C2_RFIE]) || (status[S_IDLE] && ctrl_two[C2_IDLE_IRQ_ENABLE]));
      err_irq <= !ctrl_two[C2_STBY] && // R23
                 ((status[S_OVR] && ctrl_three[0]) || (status[S_NF] && ctrl_three[1]) ||
                  (status[S_FE] && ctrl_three[2]) || (status[S_PE] && ctrl_three[3]));
    end
  end

  // Checks.
  chk_fe_with_full: assert property (@(posedge sys_clk) disable iff (!arst_n) // R3
    $rose(status[S_FE]) |-> $rose(status[S_FULL]) || status[S_OVR]) else $error("fe without full");
  chk_standby_mutes: assert property (@(posedge sys_clk) disable iff (!arst_n) // R7
    ctrl_two[C2_STBY] |=> !rx_irq) else $error("irq in standby");
  chk_overrun_keeps: assert property (@(posedge sys_clk) disable iff (!arst_n) // R14
    status[S_FULL] && char_done |=> $stable(data_buf)) else $error("buffer overwritten");
  chk_frozen_break: assert property (@(posedge sys_clk) disable iff (!arst_n) // R20
    debug_break && !break_clr_en && !char_done && !idle_hit |=> !$fell(status[S_FULL]))
    else $error("flag cleared in break");
  chk_stop_frame: assert property (@(posedge sys_clk) disable iff (!arst_n) // R1
    char_done && samp[1:0] == 2'b00 && !status[S_FULL] |=> status[S_FE]) else $error("no fe");
  chk_rx_irq: assert property (@(posedge sys_clk) disable iff (!arst_n) // R12
    status[S_FULL] && ctrl_two[C2_RFIE] && !ctrl_two[C2_STBY] |=> rx_irq) else $error("no rx irq");
  chk_err_irq: assert property (@(posedge sys_clk) disable iff (!arst_n) // R23
    status[S_FE] && ctrl_three[2] && !ctrl_two[C2_STBY] |=> err_irq) else $error("no err irq");
  chk_idle_wake: assert property (@(posedge sys_clk) disable iff (!arst_n) // R9
    idle_hit && ctrl_two[C2_STBY] && !ctrl_one[C1_WAKE] |=> !status[S_IDLE] || $past(status[S_IDLE]))
    else $error("waking idle set flag");
  cov_char: cover property (@(posedge sys_clk) char_done);
  cov_overrun: cover property (@(posedge sys_clk) $rose(status[S_OVR]));
  cov_wake: cover property (@(posedge sys_clk) $fell(ctrl_two[C2_STBY]));

endmodule
`default_nettype wire

// File: testbench/serial_tx_model.sv
/*
  Behavioural remote transmitter that drives the receive line of the block.
  Assumes the bench calls send from its own process and that the bit time is
  a whole number of system clocks, matching the divider that the bench programs.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_tx_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic sys_clk,
  // Serial line
  output var  logic rxd
);
  initial rxd = 1'b1;

  // Start bit, then nbits LSB first, then one stop bit of the given level.
  // A zero stop bit with zero data forms a break character.
  task automatic send(input logic [8:0] data, input int nbits, input logic stop);
    int i;
    @(posedge sys_clk) rxd <= 1'b0;
    repeat (BIT_CLKS - 1) @(posedge sys_clk);
    for (i = 0; i < nbits; i++) begin
      @(posedge sys_clk) rxd <= data[i];
      repeat (BIT_CLKS - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk) rxd <= stop;
    repeat (BIT_CLKS - 1) @(posedge sys_clk);
    // The line returns to its idle high level once the frame is over.
    @(posedge sys_clk) rxd <= 1'b1;
  endtask
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench for the receiver status block, with a queue model of the
  data buffer. Assumes the tick divider is set to 0, so one bit is 16 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import serial_rx_pkg::*;
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       debug_break = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire  logic rxd;
  logic [7:0] reg_rdata;
  logic       rx_irq;
  logic       err_irq;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  logic [7:0] exp_q[$];
  logic [7:0] st;
  logic [7:0] v;

  always #5 sys_clk = ~sys_clk;

  serial_rx_status DUT (.sys_clk(sys_clk), .arst_n(arst_n), .rxd(rxd),
    .debug_break(debug_break), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_irq(rx_irq),
    .err_irq(err_irq));
  serial_tx_model #(.BIT_CLKS(16)) tx (.sys_clk(sys_clk), .rxd(rxd));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well beyond the few thousand cycles the tests need.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken then.
  task automatic rd(input logic [3:0] a, output logic [7:0] dat);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 dat = reg_rdata;
  endtask

  task automatic flags(input logic [7:0] mask, input logic [7:0] expv);
    rd(REG_STATUS, st);
    check(st & mask, expv);
  endtask

  // Status read then data read empties the buffer and clears every flag.
  task automatic take_char();
    rd(REG_STATUS, st);
    rd(REG_DATA, st);
    if (exp_q.size() > 0) check(st, exp_q.pop_front());
  endtask

  initial begin
    int i;
    v = 8'($urandom(46279));
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(4'(i), st);
      check(st, (i == 6) ? TICK_DIV_RESET[7:0] : 8'h00);
    end
    $display("test reset values done");
    wr(REG_DIV, 8'h00);
    wr(REG_CTRL_ONE, 8'h20);
    wr(REG_CTRL_THR, 8'h0f);
    wr(REG_CTRL_TWO, 8'h01);
    repeat (3) begin
      v = 8'($urandom);
      tx.send({1'b0, v}, 8, 1'b1);
      exp_q.push_back(v);
      flags(8'h11, 8'h01);
      check({7'h0, rx_irq}, 8'h01);
      take_char();
      flags(8'h01, 8'h00);
    end
    $display("test reception done");
    tx.send({1'b0, v}, 8, 1'b0);
    exp_q.push_back(v);
    flags(8'h11, 8'h11);
    check({7'h0, err_irq}, 8'h01);
    take_char();
    tx.send(9'h000, 8, 1'b0);
    exp_q.push_back(8'h00);
    flags(8'h11, 8'h11);
    take_char();
    $display("test framing done");
    tx.send({1'b0, v}, 8, 1'b1);
    tx.send({1'b0, ~v}, 8, 1'b1);
    exp_q.push_back(v);
    flags(8'h05, 8'h05);
    check({7'h0, err_irq}, 8'h01);
    take_char();
    $display("test overrun done");
    wr(REG_CTRL_ONE, 8'h28);
    v = 8'($urandom);
    tx.send({1'b0, ~^v[6:0], v[6:0]}, 8, 1'b1);
    flags(8'h20, 8'h20);
    take_char();
    $display("test parity done");
    wr(REG_CTRL_ONE, 8'h22);
    wr(REG_CTRL_TWO, 8'h05);
    tx.send(9'h012, 8, 1'b1);
    flags(8'h01, 8'h00);
    check({7'h0, rx_irq}, 8'h00);
    tx.send({1'b0, 1'b1, v[6:0]}, 8, 1'b1);
    exp_q.push_back({1'b1, v[6:0]});
    flags(8'h01, 8'h01);
    rd(REG_CTRL_TWO, st);
    check(st & 8'h04, 8'h00);
    check({7'h0, rx_irq}, 8'h01);
    take_char();
    $display("test address wakeup done");
    wr(REG_CTRL_ONE, 8'h20);
    wr(REG_CTRL_TWO, 8'h07);
    repeat (12 * 16) @(posedge sys_clk);
    rd(REG_CTRL_TWO, st);
    check(st & 8'h04, 8'h00);
    flags(8'h03, 8'h00);
    $display("test idle wakeup done");
    wr(REG_CTRL_TWO, 8'h02);
    tx.send(9'h0a5, 8, 1'b1);
    take_char();
    repeat (12 * 16) @(posedge sys_clk);
    flags(8'h02, 8'h02);
    check({7'h0, rx_irq}, 8'h01);
    take_char();
    $display("test idle flag done");
    tx.send({1'b0, v}, 8, 1'b0);
    rd(REG_STATUS, st);
    debug_break <= 1'b1;
    rd(REG_DATA, st);
    flags(8'h10, 8'h10);
    debug_break <= 1'b0;
    rd(REG_DATA, st);
    flags(8'h11, 8'h00);
    wr(REG_BREAK, 8'h01);
    tx.send({1'b0, v}, 8, 1'b0);
    debug_break <= 1'b1;
    take_char();
    debug_break <= 1'b0;
    flags(8'h11, 8'h00);
    $display("test debug break done");
    give_verdict();
  end
endmodule

`default_nettype wire
